// ==== hw/node_addr_pkg.sv ====
package node_addr_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_PERIPH_TARGET = 8'h00;
	localparam logic [7:0] OFS_NODE_SELECT = 8'h01;
	localparam logic [7:0] OFS_MAKER = 8'h02;
	localparam logic [7:0] OFS_PART = 8'h03;
	localparam logic [7:0] OFS_REVISION = 8'h04;

	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int TARGET_MSB = 6;
	localparam int BROADCAST_BIT = 7;
	localparam int PERIPH_BIT = 5;
	localparam int NODE_MSB = 3;
	localparam int REV_MAJOR_LSB = 4;
	localparam logic [3:0] LAST_VALID_NODE = 4'h9;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [6:0] TARGET_RESET = 7'h00;
	localparam logic [3:0] NODE_RESET = 4'h0;
	localparam logic [7:0] DATA_ZERO = 8'h00;

	// ----------------------------------------
	// identity codes, values arbitrary
	// ----------------------------------------
	localparam logic [7:0] MAKER_CODE = 8'h5a;
	localparam logic [7:0] PART_CODE = 8'h11;
	localparam logic [3:0] REV_MAJOR = 4'h1;
	localparam logic [3:0] REV_MINOR = 4'h0;

	typedef enum logic [1:0]
	{
		to_node_regs,
		to_node_peripheral,
		to_all_nodes,
		rejected
	} route_kind_type;

endpackage

// ==== hw/route_if.sv ====
interface route_if;
	logic master;
	logic broadcast;
	logic periph;
	logic [3:0] node;

	modport ctrl (output master, output broadcast, output periph, output node);
	modport router (input master, input broadcast, input periph, input node);
endinterface

// ==== hw/access_router.sv ====
module access_router
(
	input wire logic clk,
	input wire logic resetn,
	route_if.router sel,
	input wire logic bus_req,
	input wire logic bus_write,
	output logic route_valid,
	output node_addr_pkg::route_kind_type route_kind,
	output logic [3:0] route_node
);
	import node_addr_pkg::*;

	typedef struct packed
	{
		logic valid;
		route_kind_type kind;
		logic [3:0] node;
	} router_state_type;

	router_state_type s;
	router_state_type next_s;

	// ----------------------------------------
	// destination decode
	// ----------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.valid = bus_req;
		next_s.node = sel.node;
		if (bus_req)
		begin
			// a slave never forwards bus-addressed traffic
			if (!sel.master)
				next_s.kind = rejected;
			else if (sel.broadcast && sel.periph)
				next_s.kind = rejected;
			else if (sel.broadcast && bus_write)
				next_s.kind = to_all_nodes;
			else if (sel.node > LAST_VALID_NODE)
				next_s.kind = rejected;
			else if (sel.periph)
				next_s.kind = to_node_peripheral;
			else
				next_s.kind = to_node_regs;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s <= '{valid: 1'b0, kind: to_node_regs, node: NODE_RESET};
		else
			s <= next_s;
	end

	assign route_valid = s.valid;
	assign route_kind = s.kind;
	assign route_node = s.node;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_broadcast_all;
		bus_req && bus_write && sel.master && sel.broadcast && !sel.periph |=> route_valid && route_kind == to_all_nodes;
	endproperty
	a_broadcast_all: assert property (p_broadcast_all) else $error("broadcast write not sent to all nodes");

	property p_periph_fwd;
		bus_req && sel.master && sel.periph && !sel.broadcast && sel.node <= LAST_VALID_NODE
			|=> route_kind == to_node_peripheral && route_node == $past(sel.node);
	endproperty
	a_periph_fwd: assert property (p_periph_fwd) else $error("peripheral access not forwarded");

	property p_reserved_node;
		bus_req && !sel.broadcast && sel.node > LAST_VALID_NODE |=> route_kind == rejected;
	endproperty
	a_reserved_node: assert property (p_reserved_node) else $error("reserved node number accepted");

	property p_route_pulse;
		bus_req |=> route_valid ##1 (route_valid == $past(bus_req));
	endproperty
	a_route_pulse: assert property (p_route_pulse) else $error("route answer not one cycle after request");

	c_broadcast: cover property (route_valid && route_kind == to_all_nodes);
	c_periph: cover property (route_valid && route_kind == to_node_peripheral);
endmodule

// ==== hw/node_addr_id_regs.sv ====
module node_addr_id_regs
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic master_strap,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic [6:0] periph_target_addr,
	output logic periph_target_valid,
	output logic node_is_master,
	input wire logic bus_req,
	input wire logic bus_write,
	output logic route_valid,
	output node_addr_pkg::route_kind_type route_kind,
	output logic [3:0] route_node
);
	import node_addr_pkg::*;

	typedef struct packed
	{
		logic strapped;
		logic master;
		logic [6:0] target;
		logic broadcast;
		logic periph;
		logic [3:0] node;
		logic rd_valid;
		logic [7:0] rd_data;
		logic target_valid;
	} regs_state_type;

	regs_state_type s;
	regs_state_type next_s;

	route_if sel_bus();

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	// node select byte layout, spare bits kept clear
	function automatic logic [7:0] node_select_byte(input logic b, input logic p, input logic [3:0] n);
		node_select_byte = DATA_ZERO;
		node_select_byte[BROADCAST_BIT] = b;
		node_select_byte[PERIPH_BIT] = p;
		node_select_byte[NODE_MSB:0] = n;
	endfunction

	// ----------------------------------------
	// register file
	// ----------------------------------------
	always_comb
	begin
		next_s = s;
		// strap caught once after reset release, never under reset
		if (!s.strapped)
		begin
			next_s.strapped = 1'b1;
			next_s.master = master_strap;
		end
		if (reg_wr)
		begin
			if (hit(reg_addr, OFS_PERIPH_TARGET))
				next_s.target = reg_wdata[TARGET_MSB:0];
			if (hit(reg_addr, OFS_NODE_SELECT) && s.master)
			begin
				next_s.broadcast = reg_wdata[BROADCAST_BIT];
				next_s.periph = reg_wdata[PERIPH_BIT];
				next_s.node = reg_wdata[NODE_MSB:0];
			end
			// code registers have no write path
		end
		next_s.rd_valid = reg_rd;
		next_s.rd_data = DATA_ZERO;
		if (reg_rd)
		begin
			if (hit(reg_addr, OFS_PERIPH_TARGET))
				next_s.rd_data = {1'b0, s.target};
			else if (hit(reg_addr, OFS_NODE_SELECT))
			begin
				next_s.rd_data[BROADCAST_BIT] = s.broadcast;
				next_s.rd_data[PERIPH_BIT] = s.periph;
				next_s.rd_data[NODE_MSB:0] = s.node;
			end
			else if (hit(reg_addr, OFS_MAKER))
				next_s.rd_data = MAKER_CODE;
			else if (hit(reg_addr, OFS_PART))
				next_s.rd_data = PART_CODE;
			else if (hit(reg_addr, OFS_REVISION))
				next_s.rd_data = {REV_MAJOR, REV_MINOR};
		end
		// target only drives the local peripheral port in a slave
		next_s.target_valid = next_s.strapped && !next_s.master;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s <= '{strapped: 1'b0, master: 1'b0, target: TARGET_RESET, broadcast: 1'b0, periph: 1'b0,
				node: NODE_RESET, rd_valid: 1'b0, rd_data: DATA_ZERO, target_valid: 1'b0};
		else
			s <= next_s;
	end

	assign rd_valid = s.rd_valid;
	assign rd_data = s.rd_data;
	assign periph_target_addr = s.target;
	assign periph_target_valid = s.target_valid;
	assign node_is_master = s.master;

	// ----------------------------------------
	// bus-addressed routing
	// ----------------------------------------
	assign sel_bus.master = s.master;
	assign sel_bus.broadcast = s.broadcast;
	assign sel_bus.periph = s.periph;
	assign sel_bus.node = s.node;

	access_router router
	(
		.clk(clk),
		.resetn(resetn),
		.sel(sel_bus.router),
		.bus_req(bus_req),
		.bus_write(bus_write),
		.route_valid(route_valid),
		.route_kind(route_kind),
		.route_node(route_node)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [5:0] node_sel_value;
	assign node_sel_value = {s.broadcast, s.periph, s.node};

	property p_target_store;
		reg_wr && reg_addr == OFS_PERIPH_TARGET |=> periph_target_addr == $past(reg_wdata[TARGET_MSB:0]);
	endproperty
	a_target_store: assert property (p_target_store) else $error("target address not stored");

	property p_slave_uses_target;
		s.strapped && !s.master |=> periph_target_valid;
	endproperty
	a_slave_uses_target: assert property (p_slave_uses_target) else $error("slave target not offered");

	property p_master_target_inert;
		s.strapped && s.master |=> !periph_target_valid;
	endproperty
	a_master_target_inert: assert property (p_master_target_inert) else $error("master target has effect");

	property p_target_readback;
		reg_wr && reg_addr == OFS_PERIPH_TARGET ##1 reg_rd && reg_addr == OFS_PERIPH_TARGET && !reg_wr
			|=> rd_valid && rd_data == {1'b0, $past(reg_wdata[TARGET_MSB:0], 2)};
	endproperty
	a_target_readback: assert property (p_target_readback) else $error("target readback wrong");

	property p_slave_write_ignored;
		reg_wr && reg_addr == OFS_NODE_SELECT && !s.master |=> $stable(node_sel_value);
	endproperty
	a_slave_write_ignored: assert property (p_slave_write_ignored) else $error("slave took node select write");

	property p_master_write_taken;
		reg_wr && reg_addr == OFS_NODE_SELECT && s.master
			|=> node_sel_value == {$past(reg_wdata[BROADCAST_BIT]), $past(reg_wdata[PERIPH_BIT]), $past(reg_wdata[NODE_MSB:0])};
	endproperty
	a_master_write_taken: assert property (p_master_write_taken) else $error("master node select write lost");

	property p_maker_read;
		reg_rd && reg_addr == OFS_MAKER |=> rd_valid && rd_data == MAKER_CODE;
	endproperty
	a_maker_read: assert property (p_maker_read) else $error("maker code wrong");

	property p_part_read;
		reg_rd && reg_addr == OFS_PART |=> rd_data == PART_CODE;
	endproperty
	a_part_read: assert property (p_part_read) else $error("part code wrong");

	property p_revision_read;
		reg_rd && reg_addr == OFS_REVISION |=> rd_data[7:REV_MAJOR_LSB] == REV_MAJOR && rd_data[REV_MAJOR_LSB-1:0] == REV_MINOR;
	endproperty
	a_revision_read: assert property (p_revision_read) else $error("revision code wrong");

	property p_code_write_ignored;
		reg_wr && reg_addr == OFS_MAKER ##1 reg_rd && reg_addr == OFS_MAKER |=> rd_data == MAKER_CODE;
	endproperty
	a_code_write_ignored: assert property (p_code_write_ignored) else $error("code register changed by write");

	// ----------------------------------------
	// checks: storage and role
	// ----------------------------------------
	property p_target_hold;
		!(reg_wr && reg_addr == OFS_PERIPH_TARGET) |=> $stable(periph_target_addr);
	endproperty
	a_target_hold: assert property (p_target_hold) else $error("target changed without a write");

	property p_node_hold;
		!(reg_wr && reg_addr == OFS_NODE_SELECT) |=> $stable(node_sel_value);
	endproperty
	a_node_hold: assert property (p_node_hold) else $error("node select changed without a write");

	property p_code_write_inert;
		reg_wr && reg_addr >= OFS_MAKER |=> $stable(periph_target_addr) && $stable(node_sel_value);
	endproperty
	a_code_write_inert: assert property (p_code_write_inert) else $error("code write touched storage");

	property p_strap_capture;
		!s.strapped |=> s.strapped && node_is_master == $past(master_strap);
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("role not taken from strap");

	property p_role_steady;
		s.strapped |=> $stable(node_is_master) && $stable(periph_target_valid);
	endproperty
	a_role_steady: assert property (p_role_steady) else $error("role changed after capture");

	property p_target_valid_role;
		periph_target_valid |-> !node_is_master;
	endproperty
	a_target_valid_role: assert property (p_target_valid_role) else $error("master offers target address");

	property p_slave_route_rejected;
		bus_req && s.strapped && !s.master |=> route_valid && route_kind == rejected;
	endproperty
	a_slave_route_rejected: assert property (p_slave_route_rejected) else $error("slave routed bus access");

	// ----------------------------------------
	// checks: read port
	// ----------------------------------------
	property p_read_pulse;
		!reg_rd |=> !rd_valid && rd_data == DATA_ZERO;
	endproperty
	a_read_pulse: assert property (p_read_pulse) else $error("read answer without a read");

	property p_read_old_target;
		reg_wr && reg_rd && reg_addr == OFS_PERIPH_TARGET |=> rd_valid && rd_data == {1'b0, $past(s.target)};
	endproperty
	a_read_old_target: assert property (p_read_old_target) else $error("same-cycle read not old target");

	property p_target_spare_bit;
		reg_rd && reg_addr == OFS_PERIPH_TARGET |=> !rd_data[TARGET_MSB + 1];
	endproperty
	a_target_spare_bit: assert property (p_target_spare_bit) else $error("target spare bit set");

	property p_node_readback;
		reg_rd && reg_addr == OFS_NODE_SELECT
			|=> rd_valid && rd_data == node_select_byte($past(s.broadcast), $past(s.periph), $past(s.node));
	endproperty
	a_node_readback: assert property (p_node_readback) else $error("node select readback wrong");

	property p_node_spare_bits;
		reg_rd && reg_addr == OFS_NODE_SELECT |=> (rd_data & ~node_select_byte(1'b1, 1'b1, '1)) == DATA_ZERO;
	endproperty
	a_node_spare_bits: assert property (p_node_spare_bits) else $error("node select spare bits set");

	property p_slave_node_zero;
		reg_rd && reg_addr == OFS_NODE_SELECT && s.strapped && !s.master |=> rd_data == DATA_ZERO;
	endproperty
	a_slave_node_zero: assert property (p_slave_node_zero) else $error("slave node select set");

	// ----------------------------------------
	// checks: code registers and unmapped reads
	// ----------------------------------------
	property p_part_write_ignored;
		reg_wr && reg_addr == OFS_PART ##1 reg_rd && reg_addr == OFS_PART |=> rd_data == PART_CODE;
	endproperty
	a_part_write_ignored: assert property (p_part_write_ignored) else $error("part code written");

	property p_rev_write_ignored;
		reg_wr && reg_addr == OFS_REVISION ##1 reg_rd && reg_addr == OFS_REVISION
			|=> rd_data == {REV_MAJOR, REV_MINOR};
	endproperty
	a_rev_write_ignored: assert property (p_rev_write_ignored) else $error("revision written");

	property p_id_read_valid;
		reg_rd && reg_addr >= OFS_MAKER && reg_addr <= OFS_REVISION |=> rd_valid;
	endproperty
	a_id_read_valid: assert property (p_id_read_valid) else $error("code read not answered");

	property p_unmapped_read;
		reg_rd && reg_addr > OFS_REVISION |=> rd_valid && rd_data == DATA_ZERO;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	c_slave_ignore: cover property (reg_wr && reg_addr == OFS_NODE_SELECT && !s.master);
	c_target_read: cover property (reg_rd && reg_addr == OFS_PERIPH_TARGET ##1 rd_valid);
	c_master_periph: cover property (s.master && s.periph ##1 bus_req);
endmodule

// ==== tb/host_model.sv ====
module host_model
(
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic bus_req,
	output logic bus_write
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// one host cycle
	// ----------------------------------------
	// every strobe set in one go, so back-to-back calls never drive a signal twice
	// broadcast with peripheral-enable only when a refusal is wanted
	task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
		input logic q, input logic qw);
		@(negedge clk);
		reg_wr = w;
		reg_rd = r;
		reg_addr = a;
		reg_wdata = d;
		bus_req = q;
		bus_write = qw;
	endtask

	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		bus_req = 1'b0;
		bus_write = 1'b0;
	end
endmodule

// ==== tb/node_addr_id_regs_test.sv ====
module node_addr_id_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import node_addr_pkg::*;

	logic clk, resetn, master_strap, reg_wr, reg_rd, bus_req, bus_write;
	logic [7:0] reg_addr, reg_wdata, rd_data, v, d0, d1;
	logic [6:0] periph_target_addr;
	logic periph_target_valid, node_is_master, rd_valid, route_valid, w;
	route_kind_type route_kind;
	logic [3:0] route_node;
	logic [7:0] rd_q[$];
	logic [5:0] rt_q[$];
	int failures = 0;
	int n_checks = 0;

	host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .bus_req(bus_req), .bus_write(bus_write));

	node_addr_id_regs dut_u (.clk(clk), .resetn(resetn), .master_strap(master_strap), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_valid(rd_valid),
		.rd_data(rd_data), .periph_target_addr(periph_target_addr),
		.periph_target_valid(periph_target_valid), .node_is_master(node_is_master),
		.bus_req(bus_req), .bus_write(bus_write), .route_valid(route_valid),
		.route_kind(route_kind), .route_node(route_node));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// fixed and reset values as the host should see them
	function automatic logic [7:0] id_exp(input int a);
		return a == 2 ? MAKER_CODE : a == 3 ? PART_CODE : a == 4 ? {REV_MAJOR, REV_MINOR} : DATA_ZERO;
	endfunction

	function automatic route_kind_type exp_kind(input logic m, b, p, wr, input logic [3:0] n);
		if (!m || (b && p))
			return rejected;
		if (b && wr)
			return to_all_nodes;
		if (n > LAST_VALID_NODE)
			return rejected;
		return p ? to_node_peripheral : to_node_regs;
	endfunction

	// ----------------------------------------
	// clock, watchdog, monitor
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		#50us;
		failures++;
		$display("BAD watchdog expected done seen hang");
		wrap_up();
	end

	// answers come one cycle after the request, so sampling off the rising edge is race free
	always @(negedge clk)
	begin
		if (rd_valid === 1'b1)
			chk("rd_data", rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx, rd_data);
		if (route_valid === 1'b1)
			chk("route", rt_q.size() > 0 ? {2'b00, rt_q.pop_front()} : 8'hxx, {2'b00, route_kind, route_node});
	end

	// ----------------------------------------
	// tests: master pass, then slave pass
	// ----------------------------------------
	initial
	begin
		resetn = 1'b0;
		master_strap = 1'b1;
		void'($urandom(85));
		for (int m = 1; m >= 0; m--)
		begin
			master_strap = m[0];
			@(negedge clk);
			resetn = 1'b0;
			repeat (16) @(negedge clk);
			resetn = 1'b1;
			repeat (2) @(negedge clk);
			chk("node_is_master", {7'h00, m[0]}, {7'h00, node_is_master});
			chk("periph_target_valid", {7'h00, !m[0]}, {7'h00, periph_target_valid});
			d0 = 8'($urandom);
			d1 = 8'($urandom);
			// write and read in one cycle: read returns the old value
			for (int a = 0; a <= 5; a++)
			begin
				host_u.cyc(1'b1, 1'b1, 8'(a), a == 0 ? d0 : a == 1 ? d1 : 8'($urandom), 1'b0, 1'b0);
				rd_q.push_back(id_exp(a));
			end
			for (int a = 0; a <= 5; a++)
			begin
				host_u.cyc(1'b0, 1'b1, 8'(a), 8'h00, 1'b0, 1'b0);
				rd_q.push_back(a == 0 ? {1'b0, d0[6:0]} : a == 1 ? (m ? d1 & 8'haf : 8'h00) : id_exp(a));
			end
			// write, then read on the next edge: fresh target, fixed codes
			d0 = 8'($urandom);
			host_u.cyc(1'b1, 1'b0, OFS_PERIPH_TARGET, d0, 1'b0, 1'b0);
			host_u.cyc(1'b0, 1'b1, OFS_PERIPH_TARGET, 8'h00, 1'b0, 1'b0);
			rd_q.push_back({1'b0, d0[6:0]});
			for (int a = 2; a <= 4; a++)
			begin
				host_u.cyc(1'b1, 1'b0, 8'(a), 8'($urandom), 1'b0, 1'b0);
				host_u.cyc(1'b0, 1'b1, 8'(a), 8'h00, 1'b0, 1'b0);
				rd_q.push_back(id_exp(a));
			end
			host_u.cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
			chk("periph_target_addr", {1'b0, d0[6:0]}, {1'b0, periph_target_addr});
			// every node number with every broadcast / peripheral-enable pairing
			for (int k = 0; k < 64; k++)
			begin
				v = 8'($urandom);
				v[7] = k[5];
				v[5] = k[4];
				v[3:0] = k[3:0];
				w = 1'($urandom);
				host_u.cyc(1'b1, 1'b0, OFS_NODE_SELECT, v, 1'b0, 1'b0);
				host_u.cyc(1'b0, 1'b1, OFS_NODE_SELECT, 8'h00, 1'b1, w);
				rd_q.push_back(m ? v & 8'haf : 8'h00);
				rt_q.push_back({exp_kind(m[0], v[7], v[5], w, m ? v[3:0] : 4'h0), m ? v[3:0] : 4'h0});
			end
			host_u.cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
			repeat (2) @(negedge clk);
			chk("pending", 8'h00, 8'(rd_q.size() + rt_q.size()));
		end
		wrap_up();
	end
endmodule
